// File: dv/tkc_control_tb.sv
// self-checking testbench of the timekeeper control block
`timescale 1ns/1ps

module tkc_control_tb;
   // long handshake so a status read right after a write still sees busy
   localparam int SYNC = 12;
   logic mclk = 1'b0; // 250 MHz bus clock
   logic rst_n = 1'b0; // held low for six cycles
   logic clkEn = 1'b1; // high except in the freeze scenario
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [3:0] pstrb = 4'h0;
   logic guard = 1'b0; // write guard input
   logic srcClk = 1'b0; // slow source clock pin
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic counterRunning;
   int failures = 0;
   int comparisons = 0;
   logic [31:0] seed = 32'h88e4312a; // fixed seed keeps runs repeatable
   logic [15:0] expCtrl = 16'h0000; // expected control register contents
   logic [31:0] rdat; // last read data
   logic rerr; // last error flag
   logic [31:0] dat;
   logic [31:0] r;
   int p;

   // free running clock, 4 ns period
   always #2 mclk = ~mclk;

   tkc_control #(.SYNC_CYCLES(SYNC)) uut (
      .mclk(mclk),
      .rst_n(rst_n),
      .clkEn(clkEn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .pstrb(pstrb),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .peripheralWriteGuard(guard),
      .timekeeperSourceClock(srcClk),
      .counterRunning(counterRunning)
   );

   // xorshift generator
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // expected control value after a write that the guard let through
   function automatic logic [15:0] nxt(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
      logic [15:0] n;
      n = old;
      if (s[0] && d[0]) begin
         n[0] = 1'b1;
      end else begin
         if (s[0]) begin
            n[1] = d[1];
            // fields held while the stored enable is set
            if (!old[1]) begin
               n[3:2] = d[3:2];
               n[7] = d[7] & (d[3:2] != 2'h1);
            end
         end
         if (s[1] && !old[1]) begin
            n[11:8] = d[11:8];
         end
      end
      return n;
   endfunction

   // expected counter after t ticks with compare value two
   function automatic logic [31:0] cntExp(input int m, input int t);
      case (m)
         0: return 32'(t % 3);
         1: return 32'(t);
         default: return 32'h00000000; // calendar and reserved hold
      endcase
   endfunction

   // verdict and end of run
   task automatic complete_run();
      if (failures == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // one comparison, counted
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // one apb transfer; waits for pready, bounded so a hang is counted
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] rd, output logic er);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= wr ? s : 4'h0;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 100);
      rd = prdata;
      er = pslverr;
      if (n >= 100) begin
         failures++;
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask

   // poll status until the handshake has finished
   task automatic settle();
      int n;
      n = 0;
      do begin
         apb(1'b0, 8'h04, 32'h0, 4'h0, rdat, rerr);
         n++;
      end while (rdat[7] !== 1'b0 && n < 40);
      chk("status idle", rdat, 32'h0);
   endtask

   // control write with readback during and after the handshake
   task automatic ctlWrite(input logic [31:0] d, input logic [3:0] s, input logic g);
      logic sr;
      logic busyExp;
      sr = s[0] & d[0] & !g;
      busyExp = s[0] & !g;
      guard <= g;
      apb(1'b1, 8'h00, d, s, rdat, rerr);
      guard <= 1'b0;
      chk("write error", {31'h0, rerr}, {31'h0, g});
      if (!g) begin
         expCtrl = nxt(expCtrl, d, s);
      end
      apb(1'b0, 8'h00, 32'h0, 4'h0, rdat, rerr);
      chk("control at once", rdat, {16'h0, expCtrl});
      apb(1'b0, 8'h04, 32'h0, 4'h0, rdat, rerr);
      chk("busy raised", rdat, {24'h0, busyExp, 7'h0});
      settle();
      // soft reset completes to all zeros
      if (sr) begin
         expCtrl = 16'h0000;
      end
      apb(1'b0, 8'h00, 32'h0, 4'h0, rdat, rerr);
      chk("control settled", rdat, {16'h0, expCtrl});
      chk("running", {31'h0, counterRunning}, {31'h0, expCtrl[1]});
   endtask

   // rising edges on the source pin, each level held four cycles
   task automatic srcPulse(input int n);
      repeat (n) begin
         repeat (4) @(posedge mclk);
         srcClk <= 1'b1;
         repeat (4) @(posedge mclk);
         srcClk <= 1'b0;
      end
   endtask

   // watchdog against a hung handshake
   initial begin
      repeat (30000) @(posedge mclk);
      failures++;
      complete_run();
   end

   // main sequence
   initial begin
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      apb(1'b0, 8'h00, 32'h0, 4'h0, rdat, rerr);
      chk("control reset", rdat, 32'h0);
      apb(1'b0, 8'h0c, 32'h0, 4'h0, rdat, rerr);
      chk("unmapped error", {31'h0, rerr}, 32'h1);
      apb(1'b1, 8'h08, 32'h1, 4'h1, rdat, rerr);
      // random lanes and fields, soft reset and guard now and then
      repeat (40) begin
         dat = rnd();
         r = rnd();
         if (dat[31:30] != 2'b00) begin
            dat[0] = 1'b0;
         end
         ctlWrite(dat, r[3:0], r[7:5] == 3'h0);
      end
      ctlWrite(32'h1, 4'h1, 1'b0);
      // every mode code with clear on compare and a random prescaler
      for (int m = 0; m < 4; m++) begin
         r = rnd();
         p = int'(r % 32'd3);
         apb(1'b1, 8'h18, 32'h2, 4'hf, rdat, rerr);
         ctlWrite({20'h0, 4'(p), 1'b1, 3'h0, 2'(m), 2'b00}, 4'h3, 1'b0);
         ctlWrite({20'h0, 4'(p), 1'b1, 3'h0, 2'(m), 2'b10}, 4'h1, 1'b0);
         srcPulse(20);
         repeat (10) @(posedge mclk);
         apb(1'b0, 8'h10, 32'h0, 4'h0, rdat, rerr);
         chk("count", rdat, cntExp(m, 20 >> p));
         ctlWrite(32'h1, 4'h1, 1'b0);
         apb(1'b0, 8'h18, 32'h0, 4'h0, rdat, rerr);
         chk("compare cleared", rdat, 32'h0);
      end
      // a frozen clock enable stretches busy; a control write meanwhile stalls
      apb(1'b1, 8'h00, 32'h2, 4'h1, rdat, rerr);
      expCtrl = nxt(expCtrl, 32'h2, 4'h1);
      clkEn <= 1'b0;
      repeat (20) @(posedge mclk);
      clkEn <= 1'b1;
      apb(1'b0, 8'h04, 32'h0, 4'h0, rdat, rerr);
      chk("busy frozen", rdat, 32'h80);
      ctlWrite(32'h0, 4'h1, 1'b0);
      // single byte and halfword lanes of compare 0 over a full word
      dat = rnd();
      r = rnd();
      apb(1'b1, 8'h18, dat, 4'hf, rdat, rerr);
      apb(1'b1, 8'h18, r, 4'h1, rdat, rerr);
      apb(1'b1, 8'h18, r, 4'hc, rdat, rerr);
      apb(1'b0, 8'h18, 32'h0, 4'h0, rdat, rerr);
      chk("compare lanes", rdat, {r[31:16], dat[15:8], r[7:0]});
      apb(1'b0, 8'h08, 32'h0, 4'h0, rdat, rerr);
      chk("debug kept", rdat, 32'h1);
      // reset in mid-run returns a written control register to zero
      ctlWrite(32'h0000_0a00, 4'h2, 1'b0);
      rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      expCtrl = 16'h0000;
      apb(1'b0, 8'h00, 32'h0, 4'h0, rdat, rerr);
      chk("control reset again", rdat, 32'h0);
      complete_run();
   end
endmodule

// File: hw/tkc_control.sv
// control register, enable / soft reset handshake and apb slave of the timekeeper
`timescale 1ns/1ps
`include "tkc_defs.svh"

module tkc_control #(
   parameter int SYNC_CYCLES = `TKC_SYNC_CYCLES
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clkEn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic peripheralWriteGuard,
   input wire logic timekeeperSourceClock,
   output logic counterRunning
);
   // the counter of the handshake must be able to hold the load value
   generate if (SYNC_CYCLES < 1 || SYNC_CYCLES > 15) begin : gBadSync
      $error("SYNC_CYCLES must lie in 1..15");
   end endgenerate

   localparam logic [3:0] SYNC_LOAD = 4'(SYNC_CYCLES);

   // word decode, used by read mux, error check and write commit
   function automatic logic hitAt(input logic [7:0] addr, input logic [7:0] off);
      return addr[7:2] == off[7:2];
   endfunction

   // unpack a control word into stored fields
   function automatic tkc_pkg::tkc_ctrl_t ctrlFromWord(input logic [15:0] w);
      tkc_pkg::tkc_ctrl_t c;
      c.prescale = w[`TKC_PSC_MSB:`TKC_PSC_LSB];
      c.mode = tkc_pkg::tkc_mode_t'(w[`TKC_MODE_MSB:`TKC_MODE_LSB]);
      c.enable = w[`TKC_BIT_ENABLE];
      c.clearOnCompare = w[`TKC_BIT_CLEAR_CMP];
      return c;
   endfunction

   tkc_pkg::tkc_ctrl_t ctrl_ff; // stored control fields
   tkc_pkg::tkc_ctrl_t wrFields; // fields carried by the bus write
   tkc_pkg::tkc_sync_t syncState_ff; // handshake state
   logic [3:0] syncCnt_ff; // cycles left in handshake
   logic softResetRequest_ff; // reset in progress, reads back
   logic debugControlRegister_ff; // survives soft reset
   logic [7:0] comp0_ff [4]; // compare 0, one entry per lane
   logic [31:0] comp0Word;
   logic [31:0] count; // live counter value
   logic [2:0] srcSync_ff; // source clock synchroniser
   logic srcLevel_ff; // settled source level
   logic srcEdge; // one pulse per settled rising edge
   logic [31:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;
   logic counterRunning_ff; // enable as seen by the counter
   logic access, accessDone, wrDone, ctrlWr, stall, addrErr;
   logic syncPendingFlag, softHit, softDone;
   logic [31:0] readData;

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign counterRunning = counterRunning_ff;
   assign comp0Word = {comp0_ff[3], comp0_ff[2], comp0_ff[1], comp0_ff[0]};

   // bus phase decode
   assign access = psel && penable;
   assign accessDone = access && pready_ff;
   assign wrDone = accessDone && pwrite && !pslverr_ff;
   assign ctrlWr = pwrite && hitAt(paddr, `TKC_OFF_CONTROL);
   assign wrFields = ctrlFromWord(pwdata[15:0]);
   assign syncPendingFlag = syncState_ff != tkc_pkg::SYNC_IDLE;
   // a one in the low lane on bit 0 only; a zero has no effect
   assign softHit = pstrb[0] && pwdata[`TKC_BIT_SOFT_RESET];
   assign softDone = syncState_ff == tkc_pkg::SYNC_RESET && syncCnt_ff == 4'h1;
   // control writes wait while a handshake runs instead of being lost
   assign stall = ctrlWr && syncPendingFlag && !addrErr;

   // unmapped words and guarded writes answer with an error
   always_comb begin
      addrErr = 1'b1;
      if (hitAt(paddr, `TKC_OFF_CONTROL) || hitAt(paddr, `TKC_OFF_STATUS) ||
          hitAt(paddr, `TKC_OFF_DEBUG) || hitAt(paddr, `TKC_OFF_COUNT) ||
          hitAt(paddr, `TKC_OFF_COMP0)) begin
         addrErr = 1'b0;
      end
      // read-only words ignore writes silently, guard covers the rest
      if (pwrite && peripheralWriteGuard && !hitAt(paddr, `TKC_OFF_STATUS) &&
          !hitAt(paddr, `TKC_OFF_COUNT)) begin
         addrErr = 1'b1;
      end
   end

   // read mux; unused bits stay zero
   always_comb begin
      readData = 32'h0000_0000;
      if (hitAt(paddr, `TKC_OFF_CONTROL)) begin
         readData[`TKC_PSC_MSB:`TKC_PSC_LSB] = ctrl_ff.prescale;
         readData[`TKC_BIT_CLEAR_CMP] = ctrl_ff.clearOnCompare;
         readData[`TKC_MODE_MSB:`TKC_MODE_LSB] = ctrl_ff.mode;
         readData[`TKC_BIT_ENABLE] = ctrl_ff.enable;
         readData[`TKC_BIT_SOFT_RESET] = softResetRequest_ff;
      end else if (hitAt(paddr, `TKC_OFF_STATUS)) begin
         readData[`TKC_BIT_BUSY] = syncPendingFlag;
      end else if (hitAt(paddr, `TKC_OFF_DEBUG)) begin
         readData[`TKC_BIT_DEBUG_RUN] = debugControlRegister_ff;
      end else if (hitAt(paddr, `TKC_OFF_COUNT)) begin
         readData = count;
      end else if (hitAt(paddr, `TKC_OFF_COMP0)) begin
         readData = comp0Word;
      end
   end

   // apb answer: one wait state, longer while a control write stalls
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
      end else if (clkEn) begin
         if (accessDone) begin
            // request retired at this edge
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
         end else if (access && !stall) begin
            pready_ff <= 1'b1;
            pslverr_ff <= addrErr;
            // full word is returned; the master picks its lanes
            prdata_ff <= (pwrite || addrErr) ? 32'h0000_0000 : readData;
         end
      end
   end

   // control fields; soft reset write carries nothing else
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ctrl_ff <= ctrlFromWord(`TKC_CTRL_RESET);
      end else if (clkEn) begin
         if (softDone) begin
            ctrl_ff <= ctrlFromWord(`TKC_CTRL_RESET);
         end else if (wrDone && ctrlWr && !softHit) begin
            if (pstrb[0]) begin
               // enable stays writable while running
               ctrl_ff.enable <= wrFields.enable;
            end
            // protection judged on the state before this write
            if (!ctrl_ff.enable) begin
               if (pstrb[0]) begin
                  ctrl_ff.mode <= wrFields.mode;
                  // clear-on-compare has no meaning in narrow mode
                  ctrl_ff.clearOnCompare <= wrFields.clearOnCompare &&
                     wrFields.mode != tkc_pkg::MODE_NARROW;
               end
               if (pstrb[1]) begin
                  ctrl_ff.prescale <= wrFields.prescale;
               end
            end
         end
      end
   end

   // handshake: enable or soft reset reaches the counter after SYNC_CYCLES
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         syncState_ff <= tkc_pkg::SYNC_IDLE;
         syncCnt_ff <= 4'h0;
         softResetRequest_ff <= 1'b0;
         counterRunning_ff <= 1'b0;
      end else if (clkEn) begin
         case (syncState_ff)
            tkc_pkg::SYNC_IDLE: begin
               if (wrDone && ctrlWr && pstrb[0]) begin
                  syncCnt_ff <= SYNC_LOAD;
                  if (softHit) begin
                     syncState_ff <= tkc_pkg::SYNC_RESET;
                     softResetRequest_ff <= 1'b1;
                  end else begin
                     syncState_ff <= tkc_pkg::SYNC_ENABLE;
                  end
               end
            end
            tkc_pkg::SYNC_ENABLE: begin
               if (syncCnt_ff == 4'h1) begin
                  syncState_ff <= tkc_pkg::SYNC_IDLE;
                  counterRunning_ff <= ctrl_ff.enable;
               end else begin
                  syncCnt_ff <= syncCnt_ff - 4'h1;
               end
            end
            tkc_pkg::SYNC_RESET: begin
               if (softDone) begin
                  syncState_ff <= tkc_pkg::SYNC_IDLE;
                  softResetRequest_ff <= 1'b0;
                  counterRunning_ff <= 1'b0;
               end else begin
                  syncCnt_ff <= syncCnt_ff - 4'h1;
               end
            end
            default: begin
               syncState_ff <= tkc_pkg::SYNC_IDLE;
            end
         endcase
      end
   end

   // debug control is deliberately untouched by soft reset
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         debugControlRegister_ff <= `TKC_DEBUG_RESET;
      end else if (clkEn && wrDone && pstrb[0] && hitAt(paddr, `TKC_OFF_DEBUG)) begin
         debugControlRegister_ff <= pwdata[`TKC_BIT_DEBUG_RUN];
      end
   end

   // compare 0, each byte lane written on its own strobe
   generate for (genvar i = 0; i < 4; i++) begin : gLane
      always_ff @(posedge mclk) begin
         if (!rst_n) begin
            comp0_ff[i] <= `TKC_COMP_RESET;
         end else if (clkEn) begin
            if (softDone) begin
               comp0_ff[i] <= `TKC_COMP_RESET;
            end else if (wrDone && pstrb[i] && hitAt(paddr, `TKC_OFF_COMP0)) begin
               comp0_ff[i] <= pwdata[8*i +: 8];
            end
         end
      end
   end endgenerate

   // source clock pin: three stages, a change counts once stages two and three agree
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         srcSync_ff <= 3'h0;
      end else if (clkEn) begin
         srcSync_ff <= {srcSync_ff[1:0], timekeeperSourceClock};
      end
   end

   // settled level, edge derived from it
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         srcLevel_ff <= 1'b0;
      end else if (clkEn && srcSync_ff[1] == srcSync_ff[2]) begin
         srcLevel_ff <= srcSync_ff[2];
      end
   end

   assign srcEdge = srcSync_ff[1] == srcSync_ff[2] && srcSync_ff[2] && !srcLevel_ff;

   // counter follows the stored fields directly, no handshake on them
   tkc_counter #(.CNT_W(32)) uCounter (
      .mclk(mclk),
      .rst_n(rst_n),
      .clkEn(clkEn),
      .softClear(softDone && clkEn),
      .run(counterRunning_ff),
      .cfg(ctrl_ff),
      .srcEdge(srcEdge),
      .compare(comp0Word),
      .count(count)
   );

   default clocking cbMain @(posedge mclk); endclocking
   default disable iff (!rst_n);

   enableReadback_a: assert property (
      clkEn && wrDone && ctrlWr && pstrb[0] && !softHit
      |=> ctrl_ff.enable == $past(pwdata[`TKC_BIT_ENABLE]) && syncPendingFlag)
      else $error("enable not read back with busy set");
   busyClears_a: assert property (
      clkEn && syncState_ff == tkc_pkg::SYNC_ENABLE && syncCnt_ff == 4'h1
      |=> !syncPendingFlag && counterRunning_ff == ctrl_ff.enable)
      else $error("busy or running state wrong after enable");
   protectHold_a: assert property (
      clkEn && wrDone && ctrlWr && ctrl_ff.enable
      |=> ctrl_ff.prescale == $past(ctrl_ff.prescale) && ctrl_ff.mode == $past(ctrl_ff.mode))
      else $error("protected field changed while enabled");
   directField_a: assert property (
      clkEn && wrDone && ctrlWr && pstrb == 4'b0010 && !ctrl_ff.enable
      |=> ctrl_ff.prescale == $past(pwdata[`TKC_PSC_MSB:`TKC_PSC_LSB]) && !syncPendingFlag)
      else $error("prescaler write not direct");
   softWins_a: assert property (
      clkEn && wrDone && ctrlWr && softHit
      |=> ctrl_ff == $past(ctrl_ff) && softResetRequest_ff)
      else $error("soft reset write changed other fields");
   softBusy_a: assert property (
      softResetRequest_ff |-> syncState_ff == tkc_pkg::SYNC_RESET)
      else $error("soft reset pending without busy");
   softDone_a: assert property (
      clkEn && softDone
      |=> ctrl_ff == ctrlFromWord(`TKC_CTRL_RESET) && !counterRunning_ff && !softResetRequest_ff
          && comp0Word == 32'h0000_0000 && debugControlRegister_ff == $past(debugControlRegister_ff))
      else $error("soft reset result wrong");
   laneAlone_a: assert property (
      clkEn && wrDone && pstrb == 4'b0001 && hitAt(paddr, `TKC_OFF_COMP0)
      |=> comp0Word[31:8] == $past(comp0Word[31:8]) && comp0Word[7:0] == $past(pwdata[7:0]))
      else $error("byte write touched other lanes");
   ctrlStall_a: assert property (
      access && stall |=> !pready_ff)
      else $error("control write answered during handshake");
   spareZero_a: assert property (
      pready_ff && !pslverr_ff && !pwrite && hitAt(paddr, `TKC_OFF_CONTROL)
      |-> prdata_ff[15:12] == 4'h0 && prdata_ff[6:4] == 3'h0)
      else $error("unassigned control bits not zero");
endmodule

// File: hw/tkc_counter.sv
// prescaler and counter driven by the control fields
`timescale 1ns/1ps
`include "tkc_defs.svh"

module tkc_counter #(
   parameter int CNT_W = 32
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clkEn,
   input wire logic softClear,
   input wire logic run,
   input wire tkc_pkg::tkc_ctrl_t cfg,
   input wire logic srcEdge,
   input wire logic [CNT_W-1:0] compare,
   output logic [CNT_W-1:0] count
);
   // narrow mode needs at least 16 bits
   generate if (CNT_W < 16 || CNT_W > 32) begin : gBadWidth
      $error("CNT_W must lie in 16..32");
   end endgenerate

   logic [9:0] preCnt_ff; // source edge divider
   logic [9:0] divMask; // low prescale bits set
   logic tick; // counter tick clock enable
   logic match; // compare 0 hit
   logic [CNT_W-1:0] count_ff;

   assign count = count_ff;

   // reserved codes fall back to the slowest division rather than stop the count
   always_comb begin
      divMask = 10'h3ff;
      if (cfg.prescale <= `TKC_PSC_MAX) begin
         divMask = 10'((11'h1 << cfg.prescale) - 11'h1);
      end
   end

   assign tick = srcEdge && ((preCnt_ff & divMask) == divMask);

   // narrow mode compares only the low half
   always_comb begin
      if (cfg.mode == tkc_pkg::MODE_NARROW) begin
         match = count_ff[15:0] == compare[15:0];
      end else begin
         match = count_ff == compare;
      end
   end

   // divider restarts whenever the counter is stopped
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         preCnt_ff <= 10'h000;
      end else if (clkEn) begin
         if (!run || softClear) begin
            preCnt_ff <= 10'h000;
         end else if (srcEdge) begin
            preCnt_ff <= preCnt_ff + 10'h001;
         end
      end
   end

   // counter; calendar and reserved modes hold the value unless clear on compare matches
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         count_ff <= '0;
      end else if (clkEn) begin
         if (softClear) begin
            count_ff <= '0;
         end else if (run && tick) begin
            if (cfg.clearOnCompare && cfg.mode != tkc_pkg::MODE_NARROW && match) begin
               count_ff <= '0;
            end else if (cfg.mode == tkc_pkg::MODE_NARROW) begin
               // inner cast keeps the wrap at 16 bits, the outer one only zero-extends
               count_ff <= CNT_W'(16'(count_ff[15:0] + 16'h0001));
            end else if (cfg.mode == tkc_pkg::MODE_WIDE) begin
               count_ff <= count_ff + CNT_W'(1);
            end
         end
      end
   end

   clearOnMatch_a: assert property (@(posedge mclk) disable iff (!rst_n)
      clkEn && run && tick && cfg.clearOnCompare && cfg.mode == tkc_pkg::MODE_WIDE && match |=> count_ff == '0)
      else $error("counter not cleared on compare match");
   narrowWrap_a: assert property (@(posedge mclk) disable iff (!rst_n)
      clkEn && run && tick && !softClear && cfg.mode == tkc_pkg::MODE_NARROW
      |=> count_ff == CNT_W'(16'($past(count_ff[15:0]) + 16'h0001)))
      else $error("narrow counter step wrong");
   divOne_a: assert property (@(posedge mclk) disable iff (!rst_n)
      cfg.prescale == 4'h0 |-> tick == srcEdge)
      else $error("undivided tick differs from source edge");
endmodule

// File: hw/tkc_defs.svh
// offsets, field positions, reset values and timing counts of the timekeeper control block
`ifndef TKC_DEFS_SVH
`define TKC_DEFS_SVH
// word offsets on the register bus
`define TKC_OFF_CONTROL 8'h00
`define TKC_OFF_STATUS 8'h04
`define TKC_OFF_DEBUG 8'h08
`define TKC_OFF_COUNT 8'h10
`define TKC_OFF_COMP0 8'h18
// control register field positions
`define TKC_BIT_SOFT_RESET 0
`define TKC_BIT_ENABLE 1
`define TKC_MODE_LSB 2
`define TKC_MODE_MSB 3
`define TKC_BIT_CLEAR_CMP 7
`define TKC_PSC_LSB 8
`define TKC_PSC_MSB 11
// status and debug field positions
`define TKC_BIT_BUSY 7
`define TKC_BIT_DEBUG_RUN 0
// reset values
`define TKC_CTRL_RESET 16'h0000
`define TKC_DEBUG_RESET 1'h0
`define TKC_COMP_RESET 8'h00
// largest documented prescaler code
`define TKC_PSC_MAX 4'ha
// cycles from an enable or soft reset write until it takes effect
`define TKC_SYNC_CYCLES 4
`endif

// File: hw/tkc_pkg.sv
// shared types of the timekeeper control block
package tkc_pkg;
   // operating mode, codes follow declaration order
   typedef enum logic [1:0] {MODE_WIDE, MODE_NARROW, MODE_CALENDAR, MODE_RESERVED} tkc_mode_t;
   // enable / soft reset handshake states
   typedef enum logic [1:0] {SYNC_IDLE, SYNC_ENABLE, SYNC_RESET} tkc_sync_t;
   // stored control fields
   typedef struct packed {
      logic [3:0] prescale;
      logic clearOnCompare;
      tkc_mode_t mode;
      logic enable;
   } tkc_ctrl_t;
endpackage
